/* rtl/gyro_fifo_sync.sv */
`timescale 1ns/100ps

module gyro_fifo_sync #(
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_tick,
  input wire logic rate_event,
  input wire logic [15:0] rate_x,
  input wire logic [15:0] rate_y,
  input wire logic [15:0] rate_z,
  input wire logic [15:0] temperature,
  input wire logic external_sync_pin,
  output logic [15:0] rate_x_out,
  output logic [15:0] rate_y_out,
  output logic [15:0] rate_z_out,
  output logic [15:0] temperature_out,
  output logic threshold_irq,
  output logic wake_request
);
  import gyro_fifo_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int ENTRY_W = AXES * WORD_W + AXES;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] threshold;
    logic [7:0] buf_cfg;
    logic [7:0] sync_cfg;
    logic [7:0] post_count;
    logic [7:0] control;
    logic [DEPTH-1:0][ENTRY_W-1:0] mem;
    logic [AW-1:0] head;
    logic [AW-1:0] tail;
    logic [CW-1:0] count;
    logic [1:0] sub;
    logic triggered;
    logic snap_stop;
    logic [8:0] remaining;
    logic prev_pin;
    logic ack;
    logic [31:0] dat;
    logic thr_irq;
    logic wake_req;
    logic [15:0] x_out;
    logic [15:0] y_out;
    logic [15:0] z_out;
    logic [15:0] t_out;
  } state_type;

  localparam state_type RESET_STATE = '{
    threshold: THRESHOLD_RESET,
    buf_cfg: BUF_CFG_RESET,
    sync_cfg: SYNC_CFG_RESET,
    post_count: POST_COUNT_RESET,
    control: CONTROL_RESET,
    default: '0
  };

  state_type state;
  state_type next_state;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] first_axis(
    input logic [2:0] mask,
    input logic [1:0] from
  );
    logic [1:0] r;
    r = 2'h3;
    for (int i = AXES - 1; i >= 0; i--) begin
      if (mask[i] && (2'(i) >= from)) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : first_axis

  function automatic logic [15:0] order16(
    input logic [15:0] w,
    input logic little
  );
    return little ? {w[7:0], w[15:8]} : w;
  endfunction : order16

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : wrap_inc

  // ----------------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------------
  buffer_mode_type mode;
  logic [2:0] store_mask;
  logic little;
  logic q_rise;
  logic q_fall;
  logic wake_edge;
  logic wake_low;
  logic map_rate;
  logic map_temp;

  always_comb begin
    mode = buffer_mode_type'(state.buf_cfg[BUF_MODE_LSB +: 2]);
    store_mask = state.buf_cfg[BUF_STORE_LSB +: AXES];
    little = state.control[CONTROL_ENDIAN_BIT];
    q_rise = state.sync_cfg[SYNC_RISE_BIT];
    q_fall = state.sync_cfg[SYNC_FALL_BIT];
    wake_edge = state.sync_cfg[SYNC_WAKE_EDGE_BIT];
    wake_low = state.sync_cfg[SYNC_WAKE_LOW_BIT];
    map_rate = state.sync_cfg[SYNC_MAP_RATE_BIT];
    map_temp = state.sync_cfg[SYNC_MAP_TEMP_BIT];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [5:0] idx;
  logic req;
  logic do_write;
  logic do_read;
  logic full;
  logic empty;
  logic rise;
  logic fall;
  logic queue_event;
  logic [15:0] mx;
  logic [15:0] my;
  logic [15:0] mz;
  logic [15:0] mt;
  logic [ENTRY_W-1:0] head_entry;
  logic [1:0] rd_axis;
  logic [1:0] rd_next;
  logic pop;
  logic set_done;
  logic sync_gate;
  logic mode_gate;
  logic may_overwrite;
  logic tick_ok;
  logic push;
  logic overwrite;
  logic [31:0] rdata;

  always_comb begin
    next_state = state;
    idx = wb_adr_i[7:2];
    req = wb_cyc_i && wb_stb_i;
    do_write = req && state.ack && wb_we_i && wb_sel_i[0];
    do_read = req && state.ack && !wb_we_i;
    full = (state.count == CW'(DEPTH));
    empty = (state.count == '0);

    // Sync pin sampled directly; it is taken as synchronous to sys_clk
    rise = external_sync_pin && !state.prev_pin;
    fall = !external_sync_pin && state.prev_pin;
    queue_event = (q_rise && rise) || (q_fall && fall);

    // LSB mapping and byte order shared by outputs and buffer
    mx = map_rate ? {rate_x[15:1], external_sync_pin} : rate_x;
    my = map_rate ? {rate_y[15:1], external_sync_pin} : rate_y;
    mz = map_rate ? {rate_z[15:1], external_sync_pin} : rate_z;
    mt = map_temp ? {temperature[15:1], external_sync_pin}
                  : temperature;
    mx = order16(mx, little);
    my = order16(my, little);
    mz = order16(mz, little);
    mt = order16(mt, little);

    // Head word selection; reads while off see an empty buffer
    head_entry = state.mem[state.head];
    rd_axis = first_axis(head_entry[ENTRY_W-1 -: AXES], state.sub);
    rd_next = first_axis(head_entry[ENTRY_W-1 -: AXES], rd_axis + 2'h1);
    pop = do_read && (idx == IDX_DATA) && !empty
          && (mode != MODE_OFF) && (rd_axis != 2'h3);
    // A set leaves the buffer when its last enabled word is read
    set_done = pop && (rd_next == 2'h3);

    // Collection gating by mode, sync window and full handling
    sync_gate = (q_rise || q_fall) ? (state.remaining != '0) : 1'b1;
    case (mode)
      MODE_OFF: mode_gate = 1'b0;
      MODE_NORMAL: mode_gate = 1'b1;
      MODE_INTERRUPT: mode_gate = state.triggered;
      MODE_SNAPSHOT: mode_gate = !state.snap_stop;
      default: mode_gate = 1'b0;
    endcase
    // Snapshot: overwrite before the event, stop at full after it
    if (mode == MODE_SNAPSHOT) begin
      may_overwrite = !state.triggered;
    end else begin
      may_overwrite = state.buf_cfg[BUF_OVERRUN_BIT];
    end
    // Ticks outside a sync window are dropped while queueing is enabled
    tick_ok = sample_tick && (store_mask != '0) && mode_gate
              && sync_gate;
    // A partial read at full frees no slot; the tail would land on the head
    overwrite = full && !set_done;
    push = tick_ok && (!overwrite || may_overwrite);

    // Register read data, latched when ack rises
    rdata = '0;
    case (idx)
      IDX_THRESHOLD: rdata[7:0] = state.threshold;
      IDX_BUF_CFG: rdata[7:0] = state.buf_cfg;
      IDX_SYNC_CFG: rdata[7:0] = state.sync_cfg;
      IDX_POST_COUNT: rdata[7:0] = state.post_count;
      IDX_CONTROL: rdata[7:0] = state.control;
      IDX_STATUS: begin
        rdata[15:0] = 16'(state.count);
        rdata[STATUS_FULL_BIT] = full;
        rdata[STATUS_EMPTY_BIT] = empty;
        rdata[STATUS_THRESHOLD_BIT] = state.thr_irq;
        rdata[STATUS_TRIGGERED_BIT] = state.triggered;
      end
      IDX_DATA: begin
        if (!empty && (mode != MODE_OFF) && (rd_axis != 2'h3)) begin
          rdata[15:0] = head_entry[{rd_axis, 4'h0} +: WORD_W];
        end
      end
      default: rdata = '0;
    endcase

    // Bus slave: ack one cycle after the request, side effects at its end
    next_state.ack = req && !state.ack;
    if (req && !state.ack) begin
      next_state.dat = rdata;
    end

    // Pop path
    if (pop) begin
      if (rd_next == 2'h3) begin
        next_state.head = wrap_inc(state.head);
        next_state.sub = 2'h0;
      end else begin
        next_state.sub = rd_next;
      end
    end

    // Push path; one entry is one whole set of enabled axes
    if (push) begin
      next_state.mem[state.tail] = {store_mask, mz, my, mx};
      next_state.tail = wrap_inc(state.tail);
      if (overwrite) begin
        // Oldest set is lost, even if partly read; reading resumes at the first word of the next set
        next_state.head = wrap_inc(state.head);
        next_state.sub = 2'h0;
      end
    end
    // Count moves only when a whole set enters or leaves
    if (push && !overwrite && !set_done) begin
      next_state.count = state.count + CW'(1);
    end else if (set_done && !push) begin
      next_state.count = state.count - CW'(1);
    end

    // Post-event window; a new event restarts it
    if (push && (state.remaining != '0)) begin
      next_state.remaining = state.remaining - 9'h001;
    end
    if (queue_event) begin
      next_state.remaining = 9'(state.post_count) + 9'h001;
    end

    // Register writes
    if (do_write) begin
      case (idx)
        IDX_THRESHOLD: next_state.threshold = wb_dat_i[7:0];
        IDX_BUF_CFG: begin
          next_state.buf_cfg = wb_dat_i[7:0] & BUF_CFG_WMASK;
          next_state.triggered = 1'b0;
          next_state.snap_stop = 1'b0;
          if (wb_dat_i[BUF_MODE_LSB +: 2] == 2'(MODE_OFF)) begin
            next_state.head = '0;
            next_state.tail = '0;
            next_state.count = '0;
            next_state.sub = 2'h0;
            next_state.remaining = '0;
          end
        end
        IDX_SYNC_CFG: next_state.sync_cfg = wb_dat_i[7:0] & SYNC_CFG_WMASK;
        IDX_POST_COUNT: next_state.post_count = wb_dat_i[7:0];
        IDX_CONTROL: next_state.control = {7'h00, wb_dat_i[0]};
        default: next_state.threshold = state.threshold;
      endcase
    end

    // Rate event wins over a clearing configuration write
    if (rate_event
        && ((mode == MODE_INTERRUPT) || (mode == MODE_SNAPSHOT))) begin
      next_state.triggered = 1'b1;
    end
    // Snapshot stops for good once full after the event; a write re-arms it only if no longer full, else a second write does
    if ((mode == MODE_SNAPSHOT) && state.triggered && full) begin
      next_state.snap_stop = 1'b1;
    end

    // Threshold of zero would fire on any stored set
    next_state.thr_irq = 16'(next_state.count)
                         > 16'(next_state.threshold);

    // Wake: pulse on active edge only, or follow the active level
    if (wake_edge) begin
      next_state.wake_req = wake_low ? fall : rise;
    end else begin
      next_state.wake_req = external_sync_pin ^ wake_low;
    end

    // Outputs follow the inputs one cycle late
    next_state.prev_pin = external_sync_pin;
    next_state.x_out = mx;
    next_state.y_out = my;
    next_state.z_out = mz;
    next_state.t_out = mt;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_o = state.dat;
  assign wb_ack_o = state.ack;
  assign rate_x_out = state.x_out;
  assign rate_y_out = state.y_out;
  assign rate_z_out = state.z_out;
  assign temperature_out = state.t_out;
  assign threshold_irq = state.thr_irq;
  assign wake_request = state.wake_req;

endmodule : gyro_fifo_sync

/* rtl/gyro_fifo_pkg.sv */
package gyro_fifo_pkg;

  // ----------------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_THRESHOLD = 6'h17;
  localparam logic [5:0] IDX_BUF_CFG = 6'h18;
  localparam logic [5:0] IDX_SYNC_CFG = 6'h1A;
  localparam logic [5:0] IDX_POST_COUNT = 6'h1B;
  localparam logic [5:0] IDX_CONTROL = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;
  localparam logic [5:0] IDX_DATA = 6'h22;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BUF_MODE_LSB = 6;
  localparam int BUF_INT_MODE_BIT = 5;
  localparam int BUF_OVERRUN_BIT = 4;
  localparam int BUF_STORE_LSB = 0;
  localparam int SYNC_RISE_BIT = 7;
  localparam int SYNC_FALL_BIT = 6;
  localparam int SYNC_WAKE_EDGE_BIT = 5;
  localparam int SYNC_WAKE_LOW_BIT = 4;
  localparam int SYNC_MAP_RATE_BIT = 3;
  localparam int SYNC_MAP_TEMP_BIT = 0;
  localparam int CONTROL_ENDIAN_BIT = 0;
  localparam int STATUS_FULL_BIT = 16;
  localparam int STATUS_EMPTY_BIT = 17;
  localparam int STATUS_THRESHOLD_BIT = 18;
  localparam int STATUS_TRIGGERED_BIT = 19;

  // Writable bits; reserved bits read as zero
  localparam logic [7:0] BUF_CFG_WMASK = 8'hF7;
  localparam logic [7:0] SYNC_CFG_WMASK = 8'hF9;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] BUF_CFG_RESET = 8'h00;
  localparam logic [7:0] SYNC_CFG_RESET = 8'h00;
  localparam logic [7:0] POST_COUNT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  localparam int AXES = 3;
  localparam int WORD_W = 16;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_NORMAL,
    MODE_INTERRUPT,
    MODE_SNAPSHOT
  } buffer_mode_type;

endpackage : gyro_fifo_pkg

/* sim/gyro_fifo_sync_props.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module gyro_fifo_sync_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sample_tick,
  input wire logic [15:0] rate_x,
  input wire logic external_sync_pin,
  input wire logic [15:0] rate_x_out,
  input wire logic threshold_irq,
  input wire logic wake_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [2:0] quiet;
  logic [1:0] age;
  // Quiet counts edges with a steady pin and no register access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      quiet <= 3'h0;
      age <= 2'h0;
    end else begin
      if (age != 2'h3) age <= age + 2'h1;
      if ($changed(external_sync_pin) || wb_ack_o) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  chk_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("bus request not answered");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i)
    |=> !wb_ack_o) else $error("ack without request");
  chk_dat_hold: assert property (age == 2'h3 && !wb_ack_o
    |-> $stable(wb_dat_o)) else $error("read data moved");
  chk_irq_rise: assert property ($rose(threshold_irq)
    |-> $past(sample_tick) || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("irq rose");
  chk_irq_fall: assert property ($fell(threshold_irq)
    |-> $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("irq fell");
  chk_irq_quiet: assert property ((!sample_tick && !wb_ack_o) [*3]
    |=> $stable(threshold_irq)) else $error("irq moved unprompted");
  chk_out_steady: assert property (age == 2'h3 && $stable(rate_x)
    && $stable(external_sync_pin) && !wb_ack_o && !$past(wb_ack_o)
    |=> $stable(rate_x_out)) else $error("rate output moved");
  chk_wake_quiet: assert property (quiet == 3'h7
    |-> $stable(wake_request)) else $error("wake moved on steady pin");
endmodule : gyro_fifo_sync_props

/* sim/gyro_host.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Host register bus master
// ----------------------------------------------------------------------
module gyro_host (
  input wire logic sys_clk,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // Request held until ack is sampled, at most 16 edges; address and data are scrambled on release
  task automatic xfer(input logic w, input logic [5:0] i,
    input logic [7:0] d, output logic [31:0] q, output bit late);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    late = 1'b1;
    q = 32'h0;
    for (int n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) begin
        late = 1'b0;
        q = wb_dat_o;
        break;
      end
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~wb_dat_i;
    wb_adr_i <= ~wb_adr_i;
  endtask : xfer
endmodule : gyro_host

/* sim/gyro_fifo_and_sync_event_control_tb.sv */
`timescale 1ns/100ps
module gyro_fifo_and_sync_event_control_tb;
  import gyro_fifo_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic sample_tick = 1'b0;
  logic rate_event = 1'b0;
  logic external_sync_pin = 1'b0;
  logic [15:0] rate_x = 16'h0, rate_y = 16'h0, rate_z = 16'h0;
  logic [15:0] temperature = 16'h5678;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, threshold_irq, wake_request;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] rate_x_out, rate_y_out, rate_z_out, temperature_out;
  int error_cnt = 0;
  int n_compared = 0;
  always #12.5 sys_clk = ~sys_clk;
  gyro_fifo_sync #(.DEPTH(4)) dut (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sample_tick, .rate_event, .rate_x, .rate_y, .rate_z, .temperature,
    .external_sync_pin, .rate_x_out, .rate_y_out, .rate_z_out,
    .temperature_out, .threshold_irq, .wake_request);
  gyro_host host (.sys_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d,
    output logic [31:0] q);
    bit late;
    host.xfer(w, i, d, q, late);
    if (late) begin
      error_cnt++;
      stop_test();
    end
  endtask : acc
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, i, d, q);
  endtask : wr
  task automatic rdc(input logic [5:0] i, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, i, 8'h00, q);
    chk(q, e);
  endtask : rdc
  task automatic st(input logic [15:0] n, input logic e);
    logic [31:0] q;
    acc(1'b0, IDX_STATUS, 8'h00, q);
    chk({q[STATUS_EMPTY_BIT], q[15:0]}, {e, n});
  endtask : st
  task automatic tk(input logic [15:0] v);
    @(posedge sys_clk);
    sample_tick <= 1'b1;
    rate_x <= v;
    rate_y <= v + 16'h0100;
    rate_z <= v + 16'h0200;
    @(posedge sys_clk);
    sample_tick <= 1'b0;
  endtask : tk
  task automatic ev();
    @(posedge sys_clk);
    rate_event <= 1'b1;
    @(posedge sys_clk);
    rate_event <= 1'b0;
  endtask : ev
  task automatic pin(input logic v);
    @(posedge sys_clk);
    external_sync_pin <= v;
    repeat (2) @(posedge sys_clk);
  endtask : pin
  task automatic nap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : nap
  task automatic pulses(input logic v, input int e);
    int c;
    c = 0;
    @(posedge sys_clk);
    external_sync_pin <= v;
    repeat (6) begin
      @(negedge sys_clk);
      if (wake_request === 1'b1) c++;
    end
    chk(c, e);
  endtask : pulses
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_regs();
    rdc(IDX_THRESHOLD, 32'h0);
    rdc(IDX_SYNC_CFG, 32'h0);
    wr(IDX_BUF_CFG, 8'h3F);
    rdc(IDX_BUF_CFG, 32'h37);
    wr(IDX_SYNC_CFG, 8'h06);
    rdc(IDX_SYNC_CFG, 32'h0);
    wr(6'h3F, 8'hFF);
    rdc(6'h3F, 32'h0);
    wr(IDX_BUF_CFG, 8'h00);
  endtask : s_regs
  task automatic s_normal();
    wr(IDX_THRESHOLD, 8'h02);
    wr(IDX_BUF_CFG, 8'h45);
    tk(16'h0010);
    tk(16'h0020);
    nap(1);
    chk(threshold_irq, 1'b0);
    tk(16'h0030);
    nap(1);
    chk(threshold_irq, 1'b1);
    rdc(IDX_DATA, 32'h0010);
    rdc(IDX_DATA, 32'h0210);
    nap(1);
    chk(threshold_irq, 1'b0);
    st(16'h2, 1'b0);
    for (int k = 0; k < 4; k++) rdc(IDX_DATA, 32'h20 + 32'h10 * (k / 2)
      + 32'h200 * (k % 2));
    st(16'h0, 1'b1);
    rdc(IDX_DATA, 32'h0);
  endtask : s_normal
  task automatic s_overrun();
    wr(IDX_BUF_CFG, 8'h41);
    for (int k = 1; k <= 6; k++) tk(16'(k));
    for (int k = 1; k <= 4; k++) rdc(IDX_DATA, k);
    wr(IDX_BUF_CFG, 8'h51);
    for (int k = 1; k <= 6; k++) tk(16'(k));
    for (int k = 3; k <= 6; k++) rdc(IDX_DATA, k);
  endtask : s_overrun
  task automatic s_off();
    wr(IDX_BUF_CFG, 8'h01);
    tk(16'h0007);
    nap(1);
    chk(rate_x_out, 16'h0007);
    st(16'h0, 1'b1);
    rdc(IDX_DATA, 32'h0);
  endtask : s_off
  task automatic s_int();
    wr(IDX_BUF_CFG, 8'h81);
    tk(16'h0001);
    tk(16'h0002);
    st(16'h0, 1'b1);
    ev();
    tk(16'h0005);
    rdc(IDX_DATA, 32'h5);
  endtask : s_int
  task automatic s_snap();
    wr(IDX_BUF_CFG, 8'h00);
    wr(IDX_BUF_CFG, 8'hC1);
    for (int k = 1; k <= 6; k++) tk(16'(k));
    rdc(IDX_DATA, 32'h3);
    rdc(IDX_DATA, 32'h4);
    ev();
    for (int k = 7; k <= 9; k++) tk(16'(k));
    for (int k = 5; k <= 8; k++) rdc(IDX_DATA, k);
    tk(16'h000A);
    st(16'h0, 1'b1);
  endtask : s_snap
  task automatic s_sync();
    wr(IDX_BUF_CFG, 8'h00);
    wr(IDX_POST_COUNT, 8'h01);
    wr(IDX_SYNC_CFG, 8'h88);
    wr(IDX_BUF_CFG, 8'h41);
    tk(16'h0010);
    pin(1'b1);
    for (int k = 2; k <= 4; k++) tk(16'(k * 16));
    rdc(IDX_DATA, 32'h21);
    rdc(IDX_DATA, 32'h31);
    st(16'h0, 1'b1);
    wr(IDX_POST_COUNT, 8'h00);
    wr(IDX_SYNC_CFG, 8'h40);
    pin(1'b0);
    tk(16'h0050);
    tk(16'h0060);
    rdc(IDX_DATA, 32'h50);
    st(16'h0, 1'b1);
  endtask : s_sync
  task automatic s_map();
    wr(IDX_SYNC_CFG, 8'h09);
    tk(16'h1234);
    pin(1'b1);
    nap(1);
    chk(rate_x_out, 16'h1235);
    chk(rate_y_out, 16'h1335);
    chk(rate_z_out, 16'h1435);
    chk(temperature_out, 16'h5679);
    pin(1'b0);
    nap(1);
    chk(rate_x_out, 16'h1234);
    chk(temperature_out, 16'h5678);
    wr(IDX_SYNC_CFG, 8'h00);
    wr(IDX_CONTROL, 8'h01);
    nap(2);
    chk(rate_x_out, 16'h3412);
    chk(rate_y_out, 16'h3413);
    chk(rate_z_out, 16'h3414);
    chk(temperature_out, 16'h7856);
    tk(16'h1234);
    rdc(IDX_DATA, 32'h1234);
    rdc(IDX_DATA, 32'h3412);
    wr(IDX_CONTROL, 8'h00);
  endtask : s_map
  task automatic s_reset();
    wr(IDX_THRESHOLD, 8'h05);
    tk(16'h0009);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(IDX_THRESHOLD, 32'h0);
    rdc(IDX_BUF_CFG, 32'h0);
    st(16'h0, 1'b1);
  endtask : s_reset
  task automatic s_wake();
    pin(1'b1);
    nap(1);
    chk(wake_request, 1'b1);
    wr(IDX_SYNC_CFG, 8'h10);
    nap(2);
    chk(wake_request, 1'b0);
    pin(1'b0);
    nap(1);
    chk(wake_request, 1'b1);
    wr(IDX_SYNC_CFG, 8'h20);
    nap(3);
    pulses(1'b1, 1);
    pulses(1'b0, 0);
    wr(IDX_SYNC_CFG, 8'h30);
    nap(3);
    pulses(1'b1, 0);
    pulses(1'b0, 1);
  endtask : s_wake
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    s_regs();
    s_normal();
    s_overrun();
    s_off();
    s_int();
    s_snap();
    s_sync();
    s_map();
    s_reset();
    s_wake();
    stop_test();
  end
endmodule : gyro_fifo_and_sync_event_control_tb
bind gyro_fifo_sync gyro_fifo_sync_props props (.sys_clk, .nrst, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .sample_tick, .rate_x, .external_sync_pin,
  .rate_x_out, .threshold_irq, .wake_request);
